//--- hdl/odf_pkg.sv
// Package for the optical module diagnostic status and flag bank.
// Assumes a 32-bit APB slave, one aligned word per diagnostic byte index.
package odf_pkg;
   // Register indices on the diagnostic page; byte address is index * 4
   localparam logic [7:0] ODF_IDX_STATUS = 8'h6E;
   localparam logic [7:0] ODF_IDX_ALARM_A = 8'h70;
   localparam logic [7:0] ODF_IDX_ALARM_B = 8'h71;
   localparam logic [7:0] ODF_IDX_WARN_A = 8'h74;
   localparam logic [7:0] ODF_IDX_WARN_B = 8'h75;
   // Threshold and live value block, register indices
   localparam logic [7:0] ODF_IDX_THR_BASE = 8'h00;
   localparam logic [7:0] ODF_IDX_LIVE_BASE = 8'h30;
   localparam int ODF_NUM_CH = 5;
   localparam int ODF_THR_PER_CH = 4;
   localparam int ODF_NUM_THR = 20;
   // Status bit positions
   localparam int ODF_ST_PIN_INHIBIT = 7;
   localparam int ODF_ST_SOFT_INHIBIT = 6;
   localparam int ODF_ST_RATE_SEL = 4;
   localparam int ODF_ST_TX_FAULT = 2;
   localparam int ODF_ST_SIG_LOSS = 1;
   localparam int ODF_ST_NOT_READY = 0;
   // Threshold slot order within a channel
   localparam int ODF_THR_HI_ALM = 0;
   localparam int ODF_THR_LO_ALM = 1;
   localparam int ODF_THR_HI_WRN = 2;
   localparam int ODF_THR_LO_WRN = 3;
   // Channel numbers; temperature is the only signed one
   localparam int ODF_CH_TEMP = 0;
   localparam int ODF_CH_VCC = 1;
   localparam int ODF_CH_RX = 4;
   localparam logic [15:0] ODF_THR_RESET = 16'h0000;
   localparam logic [7:0] ODF_STATUS_RESET = 8'h00;
   // Sensed values count as valid after this many cycles of power-good
   localparam int ODF_READY_CYCLES = 16;
endpackage

//--- hdl/odf_diag_flags.sv
// Status/control byte and alarm/warning flag bytes of the diagnostic page.
// Assumes sensor words arrive on pclk; pins are asynchronous and are
// synchronised here by three flip-flops.
// Functional notes
// - Status bit 7 shows the transmit-inhibit pin level.
// - Status bit 6 is a software transmit-inhibit, read and write.
// - Transmitter is disabled when pin or software inhibit is set.
// - Status bit 4 shows rate select, 1 meaning full bandwidth.
// - Receiver bandwidth stays full whatever rate select does.
// - Status bit 2 mirrors the transmit-fault output.
// - Status bit 1 mirrors the receive signal-loss output.
// - Status bit 0 is low only when powered and values valid.
// - Alarm byte A bits 7,6: temperature high and low alarm.
// - Alarm byte A bits 5,4: supply high and low alarm.
// - Alarm byte A bits 3,2: laser bias high and low alarm.
// - Alarm byte A bits 1,0: transmit power high and low alarm.
// - Alarm byte B bits 7,6: receive power alarms; rest reserved.
// - Warning byte A bits 7,6: temperature high and low warning.
// - Warning byte A bits 5,4: supply high and low warning.
// - Warning byte A bits 3,2: laser bias high and low warning.
// - Warning byte A bits 1,0: transmit power warnings.
// - Warning byte B bit 7: receive power high warning.
// - Status byte sits at diagnostic byte position 110.
// - Temperature compares as signed 16-bit, 1/256 degree steps.
// - Supply compares as unsigned 16-bit, 100 microvolt steps.
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
module odf_diag_flags
   import odf_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Module pins, asynchronous
   input wire logic tx_inhibit_pin,
   input wire logic rate_select_pin,
   input wire logic power_good,
   // Fault and signal-loss conditions from the optics
   input wire logic tx_fault_in,
   input wire logic rx_loss_in,
   // Live sensor words, on pclk
   input wire logic [15:0] live_temp,
   input wire logic [15:0] live_vcc,
   input wire logic [15:0] live_bias,
   input wire logic [15:0] live_txpwr,
   input wire logic [15:0] live_rxpwr,
   // Outputs toward the optics and host pins
   output logic tx_disable,
   output logic rx_full_bandwidth,
   output logic tx_fault_output,
   output logic receive_signal_loss_output
);
   logic [2:0] inh_sync_q;
   logic [2:0] rate_sync_q;
   logic [2:0] pwr_sync_q;
   logic [2:0] flt_sync_q;
   logic [2:0] los_sync_q;
   logic inh_q;
   logic rate_q;
   logic pwr_q;
   logic soft_inhibit_q;
   logic [4:0] ready_cnt_q;
   logic not_ready_q;
   logic [15:0] thr_q [ODF_NUM_THR];
   logic [15:0] live [ODF_NUM_CH];
   logic [ODF_NUM_CH-1:0] hi_alm, lo_alm, hi_wrn, lo_wrn;
   logic [7:0] alarm_a_q, alarm_b_q, warn_a_q, warn_b_q;
   logic [7:0] status;
   logic [7:0] idx;
   logic setup_wr;
   logic [31:0] rd_d;
   logic err_d;

   assign live[0] = live_temp;
   assign live[1] = live_vcc;
   assign live[2] = live_bias;
   assign live[3] = live_txpwr;
   assign live[4] = live_rxpwr;
   assign idx = paddr[9:2];

   // Value above limit; temperature signed, others unsigned
   function automatic logic above(input int ch, input logic [15:0] v,
                                  input logic [15:0] lim);
      if (ch == ODF_CH_TEMP) begin
         return $signed(v) > $signed(lim);
      end
      return v > lim;
   endfunction

   // Register index decode for the threshold block
   function automatic logic is_thr(input logic [7:0] i);
      return (i >= ODF_IDX_THR_BASE) &&
             (i < ODF_IDX_THR_BASE + 8'(ODF_NUM_THR));
   endfunction

   // Only word-aligned addresses in the lowest window are mapped
   function automatic logic addr_ok(input logic [11:0] a);
      return (a[11:10] == 2'h0) && (a[1:0] == 2'h0);
   endfunction

   // Byte A order: channel 0 high and low in bits 7,6, down to channel 3
   function automatic logic [7:0] pack_a(input logic [ODF_NUM_CH-1:0] hi,
                                         input logic [ODF_NUM_CH-1:0] lo);
      logic [7:0] b;
      b = 8'h00;
      for (int c = 0; c < 4; c++) begin
         b[7-2*c] = hi[c];
         b[6-2*c] = lo[c];
      end
      return b;
   endfunction

   // Byte B holds the receive channel in bits 7,6; the rest reads zero
   function automatic logic [7:0] pack_b(input logic hi, input logic lo);
      return {hi, lo, 6'h00};
   endfunction

   // Writes act in setup, so an illegal address must not alias a byte
   assign setup_wr = psel && !penable && pwrite && addr_ok(paddr);

   // Three-stage synchronisers; a change counts once stages 2 and 3 agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inh_sync_q <= 3'h0;
         rate_sync_q <= 3'h0;
         pwr_sync_q <= 3'h0;
         flt_sync_q <= 3'h0;
         los_sync_q <= 3'h0;
      end else begin
         inh_sync_q <= {inh_sync_q[1:0], tx_inhibit_pin};
         rate_sync_q <= {rate_sync_q[1:0], rate_select_pin};
         pwr_sync_q <= {pwr_sync_q[1:0], power_good};
         flt_sync_q <= {flt_sync_q[1:0], tx_fault_in};
         los_sync_q <= {los_sync_q[1:0], rx_loss_in};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inh_q <= 1'b0;
         rate_q <= 1'b0;
         pwr_q <= 1'b0;
      end else begin
         if (inh_sync_q[1] == inh_sync_q[2]) begin
            inh_q <= inh_sync_q[2];
         end
         if (rate_sync_q[1] == rate_sync_q[2]) begin
            rate_q <= rate_sync_q[2];
         end
         if (pwr_sync_q[1] == pwr_sync_q[2]) begin
            pwr_q <= pwr_sync_q[2];
         end
      end
   end

   // Readiness: power must be good and one sample period elapsed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_cnt_q <= 5'h00;
         not_ready_q <= 1'b1;
      end else if (!pwr_q) begin
         ready_cnt_q <= 5'h00;
         not_ready_q <= 1'b1;
      end else if (ready_cnt_q != 5'(ODF_READY_CYCLES)) begin
         ready_cnt_q <= ready_cnt_q + 5'h01;
         not_ready_q <= 1'b1;
      end else begin
         not_ready_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_inhibit_q <= 1'b0;
      end else if (setup_wr && pstrb[0] && idx == ODF_IDX_STATUS) begin
         soft_inhibit_q <= pwdata[ODF_ST_SOFT_INHIBIT];
      end
   end

   // Threshold words, written in setup so the answer needs no wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < ODF_NUM_THR; i++) begin
            thr_q[i] <= ODF_THR_RESET;
         end
      end else if (setup_wr && is_thr(idx)) begin
         if (pstrb[0]) begin
            thr_q[idx[4:0]][7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            thr_q[idx[4:0]][15:8] <= pwdata[15:8];
         end
      end
   end

   generate
      for (genvar c = 0; c < ODF_NUM_CH; c++) begin : g_cmp
         assign hi_alm[c] = above(c, live[c],
                                  thr_q[c*ODF_THR_PER_CH+ODF_THR_HI_ALM]);
         assign lo_alm[c] = above(c,
                                  thr_q[c*ODF_THR_PER_CH+ODF_THR_LO_ALM],
                                  live[c]);
         assign hi_wrn[c] = above(c, live[c],
                                  thr_q[c*ODF_THR_PER_CH+ODF_THR_HI_WRN]);
         assign lo_wrn[c] = above(c,
                                  thr_q[c*ODF_THR_PER_CH+ODF_THR_LO_WRN],
                                  live[c]);
      end
   endgenerate

   // Flags follow the live comparison; they are not latched, so a flag
   // drops as soon as the value is back inside its limits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_a_q <= 8'h00;
      end else begin
         alarm_a_q <= pack_a(hi_alm, lo_alm);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_b_q <= 8'h00;
      end else begin
         alarm_b_q <= pack_b(hi_alm[ODF_CH_RX], lo_alm[ODF_CH_RX]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warn_a_q <= 8'h00;
      end else begin
         warn_a_q <= pack_a(hi_wrn, lo_wrn);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warn_b_q <= 8'h00;
      end else begin
         warn_b_q <= pack_b(hi_wrn[ODF_CH_RX], lo_wrn[ODF_CH_RX]);
      end
   end

   // Transmitter stays off through reset, then follows inh_q and soft_inhibit_q from the first clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_disable <= 1'b1;
      end else begin
         tx_disable <= inh_q | soft_inhibit_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_full_bandwidth <= 1'b1;
      end else begin
         rx_full_bandwidth <= 1'b1;
      end
   end

   // Fault and loss move only when stages 2 and 3 agree, both ways,
   // so a glitch of one sampled clock on the optics side never reaches the host pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_fault_output <= 1'b0;
         receive_signal_loss_output <= 1'b0;
      end else begin
         if (flt_sync_q[1] == flt_sync_q[2]) begin
            tx_fault_output <= flt_sync_q[2];
         end
         if (los_sync_q[1] == los_sync_q[2]) begin
            receive_signal_loss_output <= los_sync_q[2];
         end
      end
   end

   always_comb begin
      status = ODF_STATUS_RESET;
      status[ODF_ST_PIN_INHIBIT] = inh_q;
      status[ODF_ST_SOFT_INHIBIT] = soft_inhibit_q;
      status[ODF_ST_RATE_SEL] = rate_q;
      status[ODF_ST_TX_FAULT] = tx_fault_output;
      status[ODF_ST_SIG_LOSS] = receive_signal_loss_output;
      status[ODF_ST_NOT_READY] = not_ready_q;
   end

   // Read mux; unmapped indices answer with an error
   always_comb begin
      rd_d = 32'h0000_0000;
      err_d = 1'b0;
      if (is_thr(idx)) begin
         rd_d = {16'h0000, thr_q[idx[4:0]]};
      end else if (idx >= ODF_IDX_LIVE_BASE &&
                   idx < ODF_IDX_LIVE_BASE + 8'(ODF_NUM_CH)) begin
         rd_d = {16'h0000, live[3'(idx - ODF_IDX_LIVE_BASE)]};
      end else begin
         case (idx)
            ODF_IDX_STATUS: rd_d = {24'h000000, status};
            ODF_IDX_ALARM_A: rd_d = {24'h000000, alarm_a_q};
            ODF_IDX_ALARM_B: rd_d = {24'h000000, alarm_b_q};
            ODF_IDX_WARN_A: rd_d = {24'h000000, warn_a_q};
            ODF_IDX_WARN_B: rd_d = {24'h000000, warn_b_q};
            default: err_d = 1'b1;
         endcase
      end
      if (!addr_ok(paddr)) begin
         err_d = 1'b1;
         rd_d = 32'h0000_0000;
      end
   end

   // One wait-free access: answer registered in setup, shown in access.
   // The cost is that ready never waits, so reads must be single-cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && !penable && err_d;
      end
   end

   // Read data holds until the next read, so a late sample still sees it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_d;
      end
   end
endmodule

//--- testbench/odf_diag_props.sv
// Checker for the diagnostic status and flag bank.
// Bound to odf_diag_flags; it sees only that module's ports.
`timescale 1ns/1ns
module odf_diag_props
   import odf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_inhibit_pin,
   input wire logic tx_fault_in,
   input wire logic rx_loss_in,
   input wire logic tx_disable,
   input wire logic rx_full_bandwidth,
   input wire logic tx_fault_output,
   input wire logic receive_signal_loss_output
);
   localparam logic [11:0] ST_ADDR = {2'b00, ODF_IDX_STATUS, 2'b00};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence soft_on_s;
      psel && penable && pwrite && pstrb[0] && pwdata[6] && paddr == ST_ADDR;
   endsequence
   sequence st_read_s;
      pready && !pwrite && paddr == ST_ADDR;
   endsequence
   access_ready_a: assert property (setup_s |=> pready && penable)
      else $error("no ready in access cycle");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   misaligned_err_a: assert property (setup_s ##0 paddr[1:0] != 2'b00
      |=> pslverr) else $error("misaligned access not refused");
   status_mapped_a: assert property (setup_s ##0 paddr == ST_ADDR
      |=> !pslverr) else $error("status access refused");
   full_bw_a: assert property (rx_full_bandwidth)
      else $error("bandwidth not full");
   soft_inhibit_a: assert property (soft_on_s
      |-> ##[0:3] tx_disable) else $error("soft inhibit ignored");
   pin_inhibit_a: assert property (tx_inhibit_pin [*8]
      |-> tx_disable) else $error("pin inhibit ignored");
   fault_mirror_a: assert property (($stable(tx_fault_in)) [*8]
      |-> tx_fault_output == tx_fault_in) else $error("fault not mirrored");
   loss_mirror_a: assert property (($stable(rx_loss_in)) [*8]
      |-> receive_signal_loss_output == rx_loss_in)
      else $error("signal loss not mirrored");
   pin_state_a: assert property (($stable(tx_inhibit_pin)) [*8] ##0
      st_read_s |-> prdata[7] == tx_inhibit_pin && prdata[31:8] == 24'h0
      && !prdata[5] && !prdata[3]) else $error("status read wrong");
endmodule
bind odf_diag_flags odf_diag_props odf_diag_props_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .tx_inhibit_pin(tx_inhibit_pin),
   .tx_fault_in(tx_fault_in), .rx_loss_in(rx_loss_in),
   .tx_disable(tx_disable), .rx_full_bandwidth(rx_full_bandwidth),
   .tx_fault_output(tx_fault_output),
   .receive_signal_loss_output(receive_signal_loss_output));

//--- testbench/odf_host_model.sv
// Host-side APB master model for the diagnostic bank.
// Its task is called by the bench; it waits for pready without limit.
`timescale 1ns/1ns
module odf_host_model (
   // Clock
   input wire logic pclk,
   // Request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   // Answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
   end
   task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released address and data lines flip so stale values cannot pass for held ones
      paddr <= ~a;
      pwdata <= ~wd;
   endtask
endmodule

//--- testbench/test_optical_module_diag_status_flags.sv
// Self-checking bench for the diagnostic status and flag bank.
// Drives pins and sensor words; the host model makes APB transfers.
`timescale 1ns/1ns
module test_optical_module_diag_status_flags;
   import odf_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [4:0] pins;
   logic [15:0] lv [5];
   logic tx_dis, full_bw, tfo, rlo;
   int fail_count, checks_done;
   logic [11:0] bad_a [3] = '{12'h1B9, 12'h3FC, 12'hDB8};
   logic [15:0] thr [4] = '{16'h03E8, 16'h0064, 16'h0320, 16'h00C8};
   logic [15:0] tv [3] = '{16'hFFFB, 16'h03E8, 16'h8000};
   logic [15:0] ov [3] = '{16'h0032, 16'h03E8, 16'h07D0};
   logic [31:0] fx [3] = '{32'h55405540, 32'h0000AA80, 32'h6A806A80};
   odf_diag_flags odf_diag_flags_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_inhibit_pin(pins[4]),
      .rate_select_pin(pins[3]), .power_good(pins[2]),
      .tx_fault_in(pins[1]), .rx_loss_in(pins[0]), .live_temp(lv[0]),
      .live_vcc(lv[1]), .live_bias(lv[2]), .live_txpwr(lv[3]),
      .live_rxpwr(lv[4]), .tx_disable(tx_dis), .rx_full_bandwidth(full_bw),
      .tx_fault_output(tfo), .receive_signal_loss_output(rlo));
   odf_host_model odf_host_model_i (.pclk(pclk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   task automatic report_and_stop();
      if (fail_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      odf_host_model_i.xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0, rd, err);
      chk({err, rd}, {1'b0, exp});
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      odf_host_model_i.xfer(1'b1, {2'b00, idx, 2'b00}, d, rd, err);
   endtask
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      report_and_stop();
   end
   initial begin
      presetn = 1'b0;
      pins = 5'h00;
      lv = '{default: 16'h0000};
      fail_count = 0;
      checks_done = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      rd_chk(ODF_IDX_STATUS, 32'h01);
      pins <= 5'h1F;
      repeat (30) @(posedge pclk);
      rd_chk(ODF_IDX_STATUS, 32'h96);
      chk({tx_dis, full_bw, tfo, rlo}, 4'hF);
      pins <= 5'h04;
      repeat (30) @(posedge pclk);
      chk({tx_dis, full_bw, tfo, rlo}, 4'h4);
      wr(ODF_IDX_STATUS, 32'h40);
      rd_chk(ODF_IDX_STATUS, 32'h40);
      chk(tx_dis, 1'b1);
      // An unmapped write must not alias onto the status byte
      odf_host_model_i.xfer(1'b1, 12'h5B8, 32'h0, rd, err);
      chk(err, 1'b1);
      rd_chk(ODF_IDX_STATUS, 32'h40);
      wr(ODF_IDX_STATUS, 32'h00);
      rd_chk(ODF_IDX_STATUS, 32'h00);
      chk(tx_dis, 1'b0);
      for (int i = 0; i < 3; i++) begin
         odf_host_model_i.xfer(1'b0, bad_a[i], 32'h0, rd, err);
         chk({err, rd}, {1'b1, 32'h0});
      end
      for (int c = 0; c < ODF_NUM_CH; c++)
         for (int s = 0; s < 4; s++)
            wr(8'(c * 4 + s), {16'h0, thr[s]});
      rd_chk(8'h05, 32'h64);
      for (int k = 0; k < 3; k++) begin
         lv <= '{tv[k], ov[k], ov[k], ov[k], ov[k]};
         repeat (3) @(posedge pclk);
         // Flag bytes are read-only, so this write must leave them alone
         wr(ODF_IDX_ALARM_A, 32'hFF);
         rd_chk(ODF_IDX_ALARM_A, fx[k][31:24]);
         rd_chk(ODF_IDX_ALARM_A, fx[k][31:24]);
         rd_chk(ODF_IDX_ALARM_B, fx[k][23:16]);
         rd_chk(ODF_IDX_WARN_A, fx[k][15:8]);
         rd_chk(ODF_IDX_WARN_A, fx[k][15:8]);
         rd_chk(ODF_IDX_WARN_B, fx[k][7:0]);
         rd_chk(ODF_IDX_LIVE_BASE, {16'h0, tv[k]});
         rd_chk(ODF_IDX_LIVE_BASE + 8'h04, {16'h0, ov[k]});
      end
      pins <= 5'h00;
      repeat (30) @(posedge pclk);
      rd_chk(ODF_IDX_STATUS, 32'h01);
      report_and_stop();
   end
endmodule
